// ==== rtl/timer_channel.sv ====
// One compare/capture channel: general register, pin and event
`timescale 1ns/1ps
module timer_channel #(
  parameter int count_width = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [count_width-1:0] timer_count,
  input wire logic wr_en,
  input wire logic [count_width-1:0] wr_data,
  input wire logic func_sel,
  input wire logic [1:0] action,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic [count_width-1:0] gen_reg,
  output logic event_pulse
);
  // ==========================================================
  // Pin synchroniser and edge detect
  logic sync1; // First stage, read only by sync2
  logic sync2; // Settled pin level
  logic prev; // Level one cycle earlier
  logic rise; // Rising edge seen
  logic fall; // Falling edge seen
  logic capture; // Capture event this cycle
  logic match_now; // Count equals general register
  logic match_prev; // Equality one cycle earlier
  logic match; // Fresh compare match

  // Two flip-flops before any logic reads the pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      sync1 <= pin_in;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // Edges from current against previous sample
  assign rise = sync2 && !prev;
  assign fall = !sync2 && prev;

  // Edge choice in capture mode
  always_comb
  begin
    if (!func_sel)
      capture = 1'b0;
    else if (action == timer_pkg::edge_rise)
      capture = rise;
    else if (action == timer_pkg::edge_fall)
      capture = fall;
    else
      capture = rise || fall;
  end

  // ==========================================================
  // Compare match, once per arrival at equality
  assign match_now = (timer_count == gen_reg);
  assign match = !func_sel && match_now && !match_prev;

  // Remember equality so a stopped count matches only once
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      match_prev <= 1'b0;
    else
      match_prev <= match_now;
  end

  // General register: capture beats a software write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      gen_reg <= timer_pkg::gen_reset;
    else if (capture)
      gen_reg <= timer_count;
    else if (wr_en)
      gen_reg <= wr_data;
  end

  // Event pulse toward the status flag
  assign event_pulse = match || capture;

  // Pin level driven on compare match
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_out <= 1'b0;
    else if (match)
    begin
      case (action)
        timer_pkg::act_low: pin_out <= 1'b0;
        timer_pkg::act_high: pin_out <= 1'b1;
        timer_pkg::act_toggle: pin_out <= !pin_out;
        default: pin_out <= pin_out;
      endcase
    end
  end

  // Drive the pin only in compare mode with an action chosen
  assign pin_oe = !func_sel && (action != timer_pkg::act_none);

  // ==========================================================
  // Checks
  capture_loads_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    capture |=> gen_reg == $past(timer_count))
    else $error("capture did not load the count");
  toggle_flips_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    match && action == timer_pkg::act_toggle |=> pin_out != $past(pin_out))
    else $error("toggle action did not flip the pin");
  rise_capture_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    func_sel && action == timer_pkg::edge_rise && $rose(sync2)
    |-> event_pulse)
    else $error("rising edge capture missed");
endmodule : timer_channel

// ==== rtl/timer_pkg.sv ====
// Shared constants for the timer status and channel pin control block
package timer_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [5:0] status_off = 6'h00;
  localparam logic [5:0] io_ab_off = 6'h04;
  localparam logic [5:0] io_cd_off = 6'h08;
  localparam logic [5:0] irq_enable_off = 6'h0c;
  localparam logic [5:0] control_off = 6'h10;
  localparam logic [5:0] count_off = 6'h14;
  localparam logic [5:0] gen_a_off = 6'h18;
  localparam logic [5:0] gen_b_off = 6'h1c;
  localparam logic [5:0] gen_c_off = 6'h20;
  localparam logic [5:0] gen_d_off = 6'h24;
  // ==========================================================
  // Field positions
  localparam int wrap_bit = 7;
  localparam int run_bit = 0;
  localparam int lo_func_bit = 2;
  localparam int hi_func_bit = 6;
  localparam int lo_act_lsb = 0;
  localparam int hi_act_lsb = 4;
  // ==========================================================
  // Reset and read-back values
  localparam logic [7:0] status_reserved = 8'h70;
  localparam logic [7:0] io_reserved = 8'h88;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] count_max = 16'hffff;
  localparam logic [15:0] gen_reset = 16'hffff;
  // ==========================================================
  // Pin action and capture edge codes
  localparam logic [1:0] act_none = 2'h0;
  localparam logic [1:0] act_low = 2'h1;
  localparam logic [1:0] act_high = 2'h2;
  localparam logic [1:0] act_toggle = 2'h3;
  localparam logic [1:0] edge_rise = 2'h0;
  localparam logic [1:0] edge_fall = 2'h1;
  // ==========================================================
  // Bus answer codes
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage : timer_pkg

// ==== rtl/timer_status_and_io_control.sv ====
// Timer status flags, channel pin control and counter behind AXI4-Lite
`timescale 1ns/1ps
// What this block does
// - Counter wrap from ffff sets wrap flag
// - Wrap flag clears after read-one then write-zero
// - Channel flags clear by read-one then write-zero
// - Status bits six to four read one
// - Channel D flag on match or capture
// - Channel C flag on match or capture
// - Channel B flag on match or capture
// - Channel A flag on match or capture
// - Bit six picks compare or capture, B
// - Bit two picks compare or capture, A
// - B action: keep, low, high, toggle
// - A action: keep, low, high, toggle
// - B capture edge: rise, fall, both
// - A capture edge: rise, fall, both
// - Control bits seven and three read one
// - Wrap request when flag and enable set
// - Channel request when flag and enable set
// - Sixteen-bit up-counter, software readable and writable
module timer_status_and_io_control #(
  parameter int count_width = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [3:0] chan_pin_in,
  output logic [3:0] chan_pin_out,
  output logic [3:0] chan_pin_oe,
  output logic wrap_irq_request,
  output logic [3:0] chan_irq_request
);
  // ==========================================================
  // Registers and state
  logic [count_width-1:0] timer_count; // Free-running count
  logic run; // Counter enable
  logic [7:0] flags; // Wrap flag at 7, channel flags at 3..0
  logic [7:0] armed; // Flag read as one, awaiting write of zero
  logic [7:0] channel_ab_io_control; // Stored fields, A and B
  logic [7:0] channel_cd_io_control; // Stored fields, C and D
  logic [4:0] irq_enable; // Wrap enable at 4, channels at 3..0
  logic [count_width-1:0] gen_reg [4]; // General registers A..D
  logic [3:0] chan_event; // Compare or capture per channel
  logic [3:0] func_sel; // Capture mode per channel
  logic [1:0] action [4]; // Action or edge field per channel
  logic [3:0] gen_wr; // Software write per general register
  logic wrap; // Counter wraps this cycle
  logic [7:0] set_vec; // Hardware set per flag
  logic [7:0] clr_vec; // Software clear per flag
  logic [7:0] status_view; // Status as read
  logic wr_go; // Write taken this cycle
  logic rd_go; // Read taken this cycle
  logic lane0; // Low byte lane enabled
  logic lanes01; // Low half-word enabled

  // ==========================================================
  // AXI4-Lite write handshake: both channels taken together
  assign wr_go = awvalid && wvalid && !bvalid;
  assign awready = wr_go;
  assign wready = wr_go;
  assign lane0 = wstrb[0];
  assign lanes01 = wstrb[0] && wstrb[1];

  // Write response one cycle after the take
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= timer_pkg::resp_okay;
    end
    else if (wr_go)
    begin
      bvalid <= 1'b1;
      case (awaddr)
        timer_pkg::status_off, timer_pkg::io_ab_off,
        timer_pkg::io_cd_off, timer_pkg::irq_enable_off,
        timer_pkg::control_off, timer_pkg::count_off,
        timer_pkg::gen_a_off, timer_pkg::gen_b_off,
        timer_pkg::gen_c_off, timer_pkg::gen_d_off:
          bresp <= timer_pkg::resp_okay;
        default: bresp <= timer_pkg::resp_slverr;
      endcase
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // ==========================================================
  // Control registers written by software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      channel_ab_io_control <= 8'h00;
      channel_cd_io_control <= 8'h00;
      irq_enable <= 5'h00;
      run <= 1'b0;
    end
    else if (wr_go && lane0)
    begin
      case (awaddr)
        timer_pkg::io_ab_off: channel_ab_io_control <= wdata[7:0];
        timer_pkg::io_cd_off: channel_cd_io_control <= wdata[7:0];
        timer_pkg::irq_enable_off: irq_enable <= wdata[4:0];
        timer_pkg::control_off: run <= wdata[timer_pkg::run_bit];
        default: run <= run;
      endcase
    end
  end

  // Per-channel mode and action fields
  assign func_sel[0] = channel_ab_io_control[timer_pkg::lo_func_bit];
  assign func_sel[1] = channel_ab_io_control[timer_pkg::hi_func_bit];
  assign func_sel[2] = channel_cd_io_control[timer_pkg::lo_func_bit];
  assign func_sel[3] = channel_cd_io_control[timer_pkg::hi_func_bit];
  assign action[0] = channel_ab_io_control[timer_pkg::lo_act_lsb +: 2];
  assign action[1] = channel_ab_io_control[timer_pkg::hi_act_lsb +: 2];
  assign action[2] = channel_cd_io_control[timer_pkg::lo_act_lsb +: 2];
  assign action[3] = channel_cd_io_control[timer_pkg::hi_act_lsb +: 2];

  // ==========================================================
  // Sixteen-bit up-counter; a software write beats counting
  assign wrap = run && (timer_count == timer_pkg::count_max)
    && !(wr_go && lanes01 && awaddr == timer_pkg::count_off);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timer_count <= timer_pkg::count_reset;
    else if (wr_go && lanes01 && awaddr == timer_pkg::count_off)
      timer_count <= wdata[count_width-1:0];
    else if (run)
      timer_count <= timer_count + count_width'(1);
  end

  // ==========================================================
  // Four channels
  assign gen_wr[0] = wr_go && lanes01 && awaddr == timer_pkg::gen_a_off;
  assign gen_wr[1] = wr_go && lanes01 && awaddr == timer_pkg::gen_b_off;
  assign gen_wr[2] = wr_go && lanes01 && awaddr == timer_pkg::gen_c_off;
  assign gen_wr[3] = wr_go && lanes01 && awaddr == timer_pkg::gen_d_off;

  for (genvar i = 0; i < 4; i++)
  begin : g_chan
    timer_channel #(
      .count_width(count_width)
    ) u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .timer_count(timer_count),
      .wr_en(gen_wr[i]),
      .wr_data(wdata[count_width-1:0]),
      .func_sel(func_sel[i]),
      .action(action[i]),
      .pin_in(chan_pin_in[i]),
      .pin_out(chan_pin_out[i]),
      .pin_oe(chan_pin_oe[i]),
      .gen_reg(gen_reg[i]),
      .event_pulse(chan_event[i])
    );
  end

  // ==========================================================
  // Status flags
  assign set_vec = {wrap, 3'h0, chan_event};
  // Clear only a flag armed by an earlier read and written zero
  assign clr_vec = (wr_go && lane0 && awaddr == timer_pkg::status_off)
    ? (~wdata[7:0] & armed) : 8'h00;

  // Set wins over clear; writing one changes nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags <= 8'h00;
    else
      flags <= ((flags & ~clr_vec) | set_vec) & 8'h8f;
  end

  // Arm on a status read that shows the flag at one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      armed <= 8'h00;
    else if (rd_go && araddr == timer_pkg::status_off)
      armed <= (armed & ~clr_vec) | flags;
    else
      armed <= armed & ~clr_vec;
  end

  assign status_view = flags | timer_pkg::status_reserved;

  // Interrupt requests follow flag and enable
  assign wrap_irq_request = flags[timer_pkg::wrap_bit] && irq_enable[4];
  assign chan_irq_request = flags[3:0] & irq_enable[3:0];

  // ==========================================================
  // AXI4-Lite read: one outstanding, data registered
  assign rd_go = arvalid && !rvalid;
  assign arready = rd_go;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= timer_pkg::resp_okay;
    end
    else if (rd_go)
    begin
      rvalid <= 1'b1;
      rresp <= timer_pkg::resp_okay;
      case (araddr)
        timer_pkg::status_off: rdata <= {24'h000000, status_view};
        timer_pkg::io_ab_off:
          rdata <= {24'h000000,
            channel_ab_io_control | timer_pkg::io_reserved};
        timer_pkg::io_cd_off:
          rdata <= {24'h000000,
            channel_cd_io_control | timer_pkg::io_reserved};
        timer_pkg::irq_enable_off: rdata <= {27'h0000000, irq_enable};
        timer_pkg::control_off: rdata <= {31'h00000000, run};
        timer_pkg::count_off: rdata <= {16'h0000, timer_count};
        timer_pkg::gen_a_off: rdata <= {16'h0000, gen_reg[0]};
        timer_pkg::gen_b_off: rdata <= {16'h0000, gen_reg[1]};
        timer_pkg::gen_c_off: rdata <= {16'h0000, gen_reg[2]};
        timer_pkg::gen_d_off: rdata <= {16'h0000, gen_reg[3]};
        default:
        begin
          rdata <= 32'h0000_0000;
          rresp <= timer_pkg::resp_slverr;
        end
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // ==========================================================
  // Checks
  wrap_sets_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wrap |=> flags[timer_pkg::wrap_bit] && timer_count == 16'h0000)
    else $error("wrap did not set the wrap flag");
  unarmed_keeps_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    flags[0] && !armed[0] |=> flags[0])
    else $error("channel A flag cleared without a prior read");
  wrap_clear_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(flags[timer_pkg::wrap_bit]) |-> $past(armed[timer_pkg::wrap_bit]))
    else $error("wrap flag cleared without a prior read");
  set_wins_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    chan_event[1] |=> flags[1])
    else $error("channel B event lost");
  status_ones_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rvalid && $past(rd_go) && $past(araddr) == timer_pkg::status_off
    |-> rdata[6:4] == 3'h7)
    else $error("status reserved bits not one");
  io_ones_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rvalid && $past(rd_go) && $past(araddr) == timer_pkg::io_ab_off
    |-> rdata[7] && rdata[3])
    else $error("control reserved bits not one");
  wrap_irq_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wrap && irq_enable[4] |=> wrap_irq_request)
    else $error("wrap request missing");
  // Channel C is the one that meets its event with the enable set
  chan_irq_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    chan_event[2] && irq_enable[2] |=> chan_irq_request[2])
    else $error("channel C request missing");
  count_step_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    run && !wr_go |=> timer_count == $past(timer_count) + 16'h0001)
    else $error("counter did not step");
  d_flag_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    chan_event[3] |=> flags[3] ##0 status_view[3])
    else $error("channel D flag not set");
  c_flag_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    chan_event[2] |=> flags[2])
    else $error("channel C flag not set");
endmodule : timer_status_and_io_control

// ==== testbench/timer_pin_partner.sv ====
// Far-side model driving the capture pins of the timer block
`timescale 1ns/1ps
module timer_pin_partner (
  input wire logic aclk,
  input wire logic [3:0] want,
  input wire logic [2:0] lag,
  output logic [3:0] chan_pin_in
);
  // ==========================================================
  // Pin driver
  // Pins idle low until the bench asks for a level
  initial chan_pin_in = 4'h0;
  // Follow the wanted level after a prompt or slow lag of whole cycles
  always
  begin
    @(want);
    repeat (lag) @(posedge aclk);
    // Change lands between edges: the device must synchronise it
    #1.3;
    chan_pin_in = want;
  end
endmodule : timer_pin_partner

// ==== testbench/timer_status_and_io_control_tb_top.sv ====
// Self-checking bench for the timer status and channel pin block
`timescale 1ns/1ps
module timer_status_and_io_control_tb_top;
  // ==========================================================
  // Signals
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, wrap_irq_request;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [3:0] wstrb, chan_pin_in, chan_pin_out, chan_pin_oe;
  logic [3:0] chan_irq_request, want;
  logic [1:0] bresp, rresp;
  logic [2:0] lag;
  logic [15:0] g;
  logic [33:0] rq[$], bq[$]; // Expected read and write answers
  int n_mismatch, total_checks, cyc;
  // ==========================================================
  // Design, partner and clock
  timer_status_and_io_control DUT (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out),
    .chan_pin_oe(chan_pin_oe), .wrap_irq_request(wrap_irq_request),
    .chan_irq_request(chan_irq_request));
  timer_pin_partner pins (.aclk(aclk), .want(want), .lag(lag),
    .chan_pin_in(chan_pin_in));
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // ==========================================================
  // Checking helpers
  task automatic check(input string what, input logic [33:0] got,
                       input logic [33:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift
  // Monitor: compare each answer with the oldest note
  always @(posedge aclk)
  begin
    if (rvalid === 1'b1 && rready === 1'b1)
      check("read", {rresp, rdata}, rq.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1)
      check("bresp", {32'h0, bresp}, bq.pop_front());
  end
  // Timeout guard
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ==========================================================
  // Bus master tasks
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] er = timer_pkg::resp_okay);
    bq.push_back({32'h0, er});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  // Read status expecting v, then write zero to clear armed flags
  task automatic flags(input logic [7:0] v);
    rd(timer_pkg::status_off, {26'h0, v});
    wr(timer_pkg::status_off, 32'h0);
  endtask : flags
  // ==========================================================
  // Main sequence
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb, want, lag} = '0;
    wstrb = 4'hf;
    seed = 32'h51;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(timer_pkg::status_off, 34'h70);
    rd(timer_pkg::io_ab_off, 34'h88);
    rd(timer_pkg::io_cd_off, 34'h88);
    rd(6'h3c, {2'h2, 32'h0});
    wr(6'h3c, 32'hffffffff, timer_pkg::resp_slverr);
    wr(timer_pkg::count_off, 32'h1234);
    rd(timer_pkg::count_off, 34'h1234);
    // Compare actions on channels A and B
    for (int ch = 0; ch < 2; ch++)
      for (int a = 0; a < 4; a++)
      begin
        g = 16'h0020 + 16'(xorshift() & 32'h1f);
        wr(timer_pkg::control_off, 32'h0);
        wr(timer_pkg::count_off, 32'h0);
        wr(timer_pkg::gen_a_off + 6'(4 * ch), {16'h0, g});
        wr(timer_pkg::io_ab_off, 32'(a << (4 * ch)));
        wr(timer_pkg::control_off, 32'h1);
        repeat (100) @(posedge aclk);
        wr(timer_pkg::control_off, 32'h0);
        check("oe", chan_pin_oe[ch], 34'(a != 0));
        if (a != 0)
          check("pin", chan_pin_out[ch], 34'(a == 2));
        // A keeps a reachable compare value, so it matches again for B
        flags(8'h70 | 8'(1 << ch) | 8'(ch));
      end
    // Wrap through ffff: wrap flag and C, D matches at ffff; C, D toggle
    wr(timer_pkg::io_ab_off, 32'h0);
    wr(timer_pkg::io_cd_off, 32'h33);
    wr(timer_pkg::irq_enable_off, 32'h1f);
    wr(timer_pkg::count_off, 32'hfffd);
    wr(timer_pkg::control_off, 32'h1);
    repeat (12) @(posedge aclk);
    wr(timer_pkg::control_off, 32'h0);
    check("wrap irq", wrap_irq_request, 34'h1);
    check("chan irq", chan_irq_request, 34'hc);
    check("cd pins", {chan_pin_oe[3:2], chan_pin_out[3:2]}, 34'hf);
    wr(timer_pkg::status_off, 32'h0);
    rd(timer_pkg::status_off, 34'hfc);
    wr(timer_pkg::status_off, 32'hff);
    rd(timer_pkg::status_off, 34'hfc);
    wr(timer_pkg::status_off, 32'h7f);
    rd(timer_pkg::status_off, 34'h7c);
    wr(timer_pkg::status_off, 32'h0);
    rd(timer_pkg::status_off, 34'h70);
    check("chan irq", chan_irq_request, 34'h0);
    wr(timer_pkg::irq_enable_off, 32'h0);
    // Capture edges on channels A and B, counter stopped
    for (int ch = 0; ch < 2; ch++)
      for (int e = 0; e < 3; e++)
      begin
        g = 16'h0100 + 16'(ch * 3 + e);
        wr(timer_pkg::count_off, {16'h0, g});
        wr(timer_pkg::io_ab_off, 32'((4 | e) << (4 * ch)));
        check("oe", chan_pin_oe[ch], 34'h0);
        lag <= 3'(xorshift());
        want[ch] <= 1'b1;
        repeat (14) @(posedge aclk);
        flags(8'h70 | (8'(e != 1) << ch));
        want[ch] <= 1'b0;
        repeat (14) @(posedge aclk);
        flags(8'h70 | (8'(e != 0) << ch));
        rd(timer_pkg::gen_a_off + 6'(4 * ch), {18'h0, g});
      end
    report_and_stop();
  end
endmodule : timer_status_and_io_control_tb_top
